// ---- rtl/ars_cfg.svh ----
/*
  Constants of the response store datapath: register offsets, reset values,
  source codes, logic lookup table and indirect bump masks.
  Assumes inclusion by bare name from the package and the datapath module.
*/
`ifndef ARS_CFG_SVH
`define ARS_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define ARS_CMD_OFS      8'h00
`define ARS_COMMON_OFS   8'h04
`define ARS_ENABLE_OFS   8'h08
`define ARS_PTR_OFS      8'h0c
`define ARS_CNT_OFS      8'h10
`define ARS_VSEL_OFS     8'h14
`define ARS_VDATA_OFS    8'h18

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ARS_COMMON_RST   32'h0000_0000
`define ARS_ENABLE_RST   32'h0000_0001
`define ARS_PTR_RST      32'h0000_0000
`define ARS_CNT_RST      24'h00_0000
`define ARS_VSEL_RST     10'h000
`define ARS_RS_RST       256'h0

// ----------------------------------------------------------------
// Input source codes and fixed figures
// ----------------------------------------------------------------
`define ARS_SRC_COMMON   3'h0
`define ARS_SRC_MASK     3'h1
`define ARS_SRC_OPND     3'h2
`define ARS_SRC_ACC      3'h3
`define ARS_SRC_ARRAY    3'h5
`define ARS_SRC_RESOLVE  3'h6
`define ARS_HSIZE_WORD   3'h2
// Truth table per logic code c at [4c+3:4c], bit index {old, input}
`define ARS_LOGIC_LUT    64'h3726fbea0415c8d9
// Pointer nibble sets that bump pointer one, two and three
`define ARS_BUMP1_SET    16'h0aae
`define ARS_BUMP2_SET    16'h00c0
`define ARS_BUMP3_SET    16'h0c00

`endif

// ---- rtl/ars_pkg.sv ----
/*
  Types of the response store datapath: instruction word layout and the
  pointer and counter register layouts.
  Assumes ars_cfg.svh is on the include path.
*/
`default_nettype none
package ars_pkg;
  `include "ars_cfg.svh"

  // ----------------------------------------------------------------
  // Instruction word, most significant field first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] op;        // Opcode byte
    logic [7:0] addr;      // Address, indirect code or shift constant
    logic [3:0] f1;        // Logic code when common bit is one
    logic [3:0] f2;        // Logic code when common bit is zero
    logic       kx;        // Update accumulator
    logic       ky;        // Update operand register
    logic       k4;        // Accumulator takes input, not operand
    logic       shift_en;  // Apply shift constant
    logic       mirror;    // Reverse end for end first
    logic [2:0] src;       // Input source
  } ins_t;

  typedef struct packed {
    logic [7:0] shift_pointer;
    logic [7:0] pointer_three;
    logic [7:0] pointer_two;
    logic [7:0] pointer_one;
  } ptrs_t;

  typedef struct packed {
    logic [7:0] bit_count_counter;
    logic [7:0] length_counter_two;
    logic [7:0] length_counter_one;
  } cnts_t;
endpackage
`default_nettype wire

// ---- rtl/response_store_ops.sv ----
/*
  Response store datapath: accumulator, operand and write-select registers of
  every array, the array memories, shift/mirror network, logic unit, pointers
  and counters, all behind an AHB-Lite slave.
  Assumes a single 200 MHz hclk, a single AHB master, word transfers only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ars_cfg.svh"

module response_store_ops #(
  parameter int N_ARR = 2
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  import ars_pkg::*;

  // Literals cannot be indexed directly, so the tables live in named constants
  localparam logic [63:0] LOGIC_LUT = `ARS_LOGIC_LUT;
  localparam logic [15:0] BUMP1_SET = `ARS_BUMP1_SET;
  localparam logic [15:0] BUMP2_SET = `ARS_BUMP2_SET;
  localparam logic [15:0] BUMP3_SET = `ARS_BUMP3_SET;

  logic            wr_pend_r;
  logic [7:0]      waddr_r;
  logic [31:0]     cmd_r;
  logic [31:0]     common_r;
  logic [N_ARR-1:0] en_r;
  ptrs_t           ptr_r;
  cnts_t           cnt_r;
  logic [9:0]      vsel_r;
  logic [255:0]    x_r [N_ARR];
  logic [255:0]    y_r [N_ARR];
  logic [255:0]    m_r [N_ARR];
  logic [255:0]    mem [N_ARR][256];
  ins_t            ins;
  logic            wr_cmd;
  logic            is_store;
  logic            is_mask;
  logic            is_word;
  logic            is_ind;
  logic            chained;
  logic            masked;
  logic [7:0]      arr_addr;
  logic [7:0]      sc;
  logic [3:0]      fn;
  logic [2:0]      field;
  logic            seen;
  logic            run;
  logic [3:0]      ones;
  logic [8:0]      mod_m;
  logic [7:0]      mm1;
  logic [7:0]      amt;
  logic [N_ARR-1:0] ny;
  logic            any_y;
  logic [31:0]     rd_data;
  logic [31:0]     view_word;

  // ----------------------------------------------------------------
  // Logic unit
  // ----------------------------------------------------------------
  // Bitwise lookup of a two-input function of old value r and input f
  function automatic logic [255:0] lf(input logic [3:0] c, input logic [255:0] r,
                                      input logic [255:0] f);
    logic [3:0] l;
    l = LOGIC_LUT[{c, 2'b00} +: 4];
    lf = (~r & ~f & {256{l[0]}}) | (~r & f & {256{l[1]}})
       | (r & ~f & {256{l[2]}}) | (r & f & {256{l[3]}});
  endfunction

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // The instruction executes on the edge that ends its write data phase
  assign ins      = ins_t'(hwdata);
  assign wr_cmd   = wr_pend_r && (waddr_r == `ARS_CMD_OFS);
  assign is_store = ins.op[4];
  assign is_mask  = ins.op[3] & ~ins.op[4];
  assign is_word  = ins.op[2];
  assign is_ind   = ins.op[0];
  assign chained  = is_ind && (ins.addr[7:6] == 2'b11);
  assign masked   = ~ins.op[3];
  // Array ops carry an address in bits 16-23, so they shift via shift_pointer
  assign sc       = (ins.op[1] | ins.op[3] | ins.op[4]) ? ptr_r.shift_pointer : ins.addr;
  assign fn       = common_r[ptr_r.pointer_one[4:0]] ? ins.f1 : ins.f2;
  assign field    = chained ? ins.addr[2:0] : ins.addr[7:5];

  // Address from instruction or from the pointer named by the top two address bits
  always_comb begin
    case (ins.addr[7:6])
      2'b00:   arr_addr = ptr_r.pointer_one;
      2'b01:   arr_addr = ptr_r.pointer_two;
      2'b10:   arr_addr = ptr_r.pointer_three;
      default: arr_addr = ptr_r.pointer_two;
    endcase
    if (!is_ind) begin
      arr_addr = ins.addr;
    end
  end

  // Shift constant: leading one gives modulus, run of ones gives amount
  always_comb begin
    seen  = 1'b0;
    run   = 1'b0;
    ones  = 4'h0;
    mod_m = 9'h100;
    for (int k = 7; k >= 0; k--) begin
      if (!seen && sc[k]) begin
        seen  = 1'b1;
        run   = 1'b1;
        ones  = 4'h1;
        mod_m = 9'(9'h2 << k);
      end else if (run && sc[k]) begin
        ones = 4'(ones + 4'h1);
      end else begin
        run = 1'b0;
      end
    end
    mm1 = 8'(mod_m - 9'h1);
    amt = seen ? 8'(mod_m >> ones) : 8'h00;
  end

  assign any_y = |ny;

  // ----------------------------------------------------------------
  // Per-array datapath
  // ----------------------------------------------------------------
  for (genvar a = 0; a < N_ARR; a++) begin : g_arr
    logic [255:0] col;
    logic [255:0] src;
    logic [255:0] mir;
    logic [255:0] rot;
    logic [255:0] net;
    logic [255:0] xn;
    logic [255:0] yn;
    logic         part;

    // Single-array ops ignore the enable mask, all-array ops obey it
    assign part  = chained ? (ptr_r.pointer_one[4:0] == 5'(a)) : en_r[a];
    assign ny[a] = en_r[a] & (|y_r[a]);

    // Column fetch, mirror and group rotation, one slice per bit
    for (genvar j = 0; j < 256; j++) begin : g_bit
      localparam logic [7:0] J = 8'(j);
      assign col[j] = mem[a][j][arr_addr];
      assign mir[j] = ins.mirror ? src[255-j] : src[j];
      assign rot[j] = mir[(J & ~mm1) | (8'(J - amt) & mm1)];
    end
    assign net = ins.shift_en ? rot : mir;

    // Input source select
    always_comb begin
      src = '0;
      case (ins.src)
        `ARS_SRC_COMMON:  src[{field, 5'b0} +: 32] = common_r;
        `ARS_SRC_MASK:    src = m_r[a];
        `ARS_SRC_OPND:    src = y_r[a];
        `ARS_SRC_ACC:     src = x_r[a];
        `ARS_SRC_ARRAY:   src = is_word ? mem[a][arr_addr] : col;
        `ARS_SRC_RESOLVE: src = any_y ? y_r[a] : x_r[a];
        default:          src = '0;
      endcase
    end

    // New accumulator and operand values
    always_comb begin
      if (ins.src == `ARS_SRC_RESOLVE && ins.kx && ins.ky) begin
        xn = any_y ? y_r[a] : x_r[a];
        yn = any_y ? y_r[a] : x_r[a];
      end else begin
        xn = ins.kx ? lf(fn, x_r[a], (ins.ky && !ins.k4) ? y_r[a] : net) : x_r[a];
        yn = ins.ky ? lf(fn, y_r[a], net) : y_r[a];
      end
    end

    // Register update, stores included so logic rides along
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        x_r[a] <= `ARS_RS_RST;
        y_r[a] <= `ARS_RS_RST;
        m_r[a] <= `ARS_RS_RST;
      end else if (wr_cmd && part) begin
        if (is_mask) begin
          m_r[a] <= net;
        end else begin
          x_r[a] <= xn;
          y_r[a] <= yn;
        end
      end
    end

    // Array memory writes; no reset, contents are software data
    always_ff @(posedge hclk) begin
      if (wr_cmd && part && is_store && !(masked && ins.src == `ARS_SRC_MASK)) begin
        for (int k = 0; k < 256; k++) begin
          if (!masked || m_r[a][k]) begin
            if (is_word) begin
              mem[a][arr_addr][k] <= net[k];
            end else begin
              mem[a][k][arr_addr] <= net[k];
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pointers and counters
  // ----------------------------------------------------------------
  // Software load wins; otherwise indirect instructions bump
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_r <= ptrs_t'(`ARS_PTR_RST);
    end else if (wr_pend_r && waddr_r == `ARS_PTR_OFS) begin
      ptr_r <= ptrs_t'(hwdata);
    end else if (wr_cmd && is_ind) begin
      if (BUMP1_SET[ins.addr[7:4]]) begin
        ptr_r.pointer_one <= ins.addr[2] ? 8'(ptr_r.pointer_one - 8'h1)
                                         : 8'(ptr_r.pointer_one + 8'h1);
      end
      if (BUMP2_SET[ins.addr[7:4]]) begin
        ptr_r.pointer_two <= ins.addr[2] ? 8'(ptr_r.pointer_two - 8'h1)
                                         : 8'(ptr_r.pointer_two + 8'h1);
      end
      if (BUMP3_SET[ins.addr[7:4]]) begin
        ptr_r.pointer_three <= ins.addr[2] ? 8'(ptr_r.pointer_three - 8'h1)
                                           : 8'(ptr_r.pointer_three + 8'h1);
      end
      // Chained pointer: one and two act as one 16-bit pointer
      case (ins.addr[7:4])
        4'hd: {ptr_r.pointer_one, ptr_r.pointer_two} <=
                16'({ptr_r.pointer_one, ptr_r.pointer_two} - 16'h1);
        4'he: {ptr_r.pointer_one, ptr_r.pointer_two} <=
                16'({ptr_r.pointer_one, ptr_r.pointer_two} + 16'h1);
        4'hf: {ptr_r.pointer_one, ptr_r.pointer_two} <= common_r[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= cnts_t'(`ARS_CNT_RST);
    end else if (wr_pend_r && waddr_r == `ARS_CNT_OFS) begin
      cnt_r <= cnts_t'(hwdata[23:0]);
    end else if (wr_cmd && is_ind) begin
      case (ins.addr[1:0])
        2'h1:    cnt_r.length_counter_one <= 8'(cnt_r.length_counter_one - 8'h1);
        2'h2:    cnt_r.length_counter_two <= 8'(cnt_r.length_counter_two - 8'h1);
        2'h3:    cnt_r.bit_count_counter  <= 8'(cnt_r.bit_count_counter - 8'h1);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r    <= 32'h0;
      common_r <= `ARS_COMMON_RST;
      en_r     <= N_ARR'(`ARS_ENABLE_RST);
      vsel_r   <= `ARS_VSEL_RST;
    end else if (wr_pend_r) begin
      case (waddr_r)
        `ARS_CMD_OFS:    cmd_r    <= hwdata;
        `ARS_COMMON_OFS: common_r <= hwdata;
        `ARS_ENABLE_OFS: en_r     <= hwdata[N_ARR-1:0];
        `ARS_VSEL_OFS:   vsel_r   <= hwdata[9:0];
        default: ;
      endcase
    end
  end

  // Window onto one 32-bit field of one register of one array
  always_comb begin
    view_word = 32'h0;
    for (int a = 0; a < N_ARR; a++) begin
      if (vsel_r[4:0] == 5'(a)) begin
        case (vsel_r[6:5])
          2'h0:    view_word = x_r[a][{vsel_r[9:7], 5'b0} +: 32];
          2'h1:    view_word = y_r[a][{vsel_r[9:7], 5'b0} +: 32];
          2'h2:    view_word = m_r[a][{vsel_r[9:7], 5'b0} +: 32];
          default: view_word = 32'h0;
        endcase
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 32'h0;
    if (haddr[31:8] == 24'h0) begin
      case (haddr[7:0])
        `ARS_CMD_OFS:    rd_data = cmd_r;
        `ARS_COMMON_OFS: rd_data = common_r;
        `ARS_ENABLE_OFS: rd_data = 32'(en_r);
        `ARS_PTR_OFS:    rd_data = ptr_r;
        `ARS_CNT_OFS:    rd_data = {8'h0, cnt_r};
        `ARS_VSEL_OFS:   rd_data = {22'h0, vsel_r};
        `ARS_VDATA_OFS:  rd_data = view_word;
        default:         rd_data = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  // Read data is registered at the address phase, so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_r <= hwrite && (hsize == `ARS_HSIZE_WORD) && (haddr[31:8] == 24'h0);
        waddr_r   <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_data;
        end
      end else begin
        wr_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [255:0] x0_mirror;

  // Reference reversal of array 0's accumulator, built apart from the network
  always_comb begin
    for (int k = 0; k < 256; k++) begin
      x0_mirror[k] = x_r[0][255-k];
    end
  end

  property p_clear_acc;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd && ins.op == 8'h00 && ins[15:5] == 11'b01110111101 && en_r[0]
    |=> x_r[0] == 256'h0;
  endproperty
  a_clear_acc: assert property (p_clear_acc) else $error("accumulator not cleared");

  property p_pass_opnd;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd && hwdata == 32'h000088a2 && en_r[0] |=> x_r[0] == $past(y_r[0]);
  endproperty
  a_pass_opnd: assert property (p_pass_opnd) else $error("input code did not pass");

  property p_mirror;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd && hwdata == 32'h0000884b && en_r[0] |=> y_r[0] == $past(x0_mirror);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror not end for end");

  property p_disabled_keep;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd && !en_r[0] && !chained |=> x_r[0] == $past(x_r[0]) && y_r[0] == $past(y_r[0]);
  endproperty
  a_disabled_keep: assert property (p_disabled_keep) else $error("disabled array changed");

  property p_dec_ptr1;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd && hwdata == 32'h01340000
    |=> ptr_r.pointer_one == 8'($past(ptr_r.pointer_one) - 8'h1);
  endproperty
  a_dec_ptr1: assert property (p_dec_ptr1) else $error("pointer one not decremented");

  property p_dec_bits;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd && hwdata == 32'h01030000
    |=> cnt_r.bit_count_counter == 8'($past(cnt_r.bit_count_counter) - 8'h1)
        && ptr_r == $past(ptr_r);
  endproperty
  a_dec_bits: assert property (p_dec_bits) else $error("bit count not decremented");

  property p_common_field;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd && hwdata == 32'h02e088a0 && en_r[0]
    |=> x_r[0] == {$past(common_r), 224'h0};
  endproperty
  a_common_field: assert property (p_common_field) else $error("common field load wrong");

  property p_resolve_keep;
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd && hwdata == 32'h000088a6 && !any_y && en_r[0] |=> x_r[0] == $past(x_r[0]);
  endproperty
  a_resolve_keep: assert property (p_resolve_keep) else $error("resolve changed acc");

  property p_bus_okay;
    @(posedge hclk) disable iff (!hresetn)
    hsel && htrans[1] |-> ##1 hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready okay");
endmodule // response_store_ops
`default_nettype wire

// ---- test/ahb_master_model.sv ----
/*
  Bus master model standing in for the instruction-issuing controller: single
  word transfers on AHB-Lite, one task for reads and writes.
  Assumes one slave whose hreadyout is hready and a free-running hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ahb_master_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  // --------------------------------------------------------------
  // Idle bus from time zero
  // --------------------------------------------------------------
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // --------------------------------------------------------------
  // One transfer; called just after a rising edge
  // --------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Released data lines do not keep the last value
    hwdata <= ~wd;
  endtask
endmodule // ahb_master_model
`default_nettype wire

// ---- test/associative_response_store_ops_tb_top.sv ----
/*
  Self-checking bench of the response store datapath: reset values, a table of
  instruction rows, then copy, resolve, pointer and common-bit cases.
  Assumes ars_cfg.svh on the include path and the bus master model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ars_cfg.svh"
module associative_response_store_ops_tb_top;
  import ars_pkg::*;
  typedef struct packed {
    logic [1:0]  en;
    logic [31:0] com;
    logic [31:0] cmd;
    logic [9:0]  vsel;
    logic [31:0] exp;
  } row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  int          n_mismatch = 0;
  int          num_checks = 0;
  // Rows run in order; most lean on the state left by the ones before
  row_t rows [0:27] = '{
    '{2'h1, 32'h000000f0, 32'h020088a0, 10'h000, 32'h000000f0},
    '{2'h1, 32'h000000aa, 32'h020099a0, 10'h000, 32'h000000fa},
    '{2'h1, 32'h000000ff, 32'h0200cca0, 10'h000, 32'h00000005},
    '{2'h1, 32'h00000000, 32'h0000bba3, 10'h380, 32'hffffffff},
    '{2'h1, 32'h00000000, 32'h00008843, 10'h1a0, 32'hffffffff},
    '{2'h1, 32'h12345678, 32'h02e088a0, 10'h380, 32'h12345678},
    '{2'h1, 32'h00000000, 32'h000033a2, 10'h380, 32'h12345678},
    '{2'h1, 32'h00000000, 32'h0000884b, 10'h020, 32'h1e6a2c48},
    '{2'h1, 32'h00000000, 32'h00e088b2, 10'h080, 32'h1e6a2c48},
    '{2'h1, 32'h00000000, 32'h001e8852, 10'h020, 32'h79a8b120},
    '{2'h1, 32'h00000000, 32'h00808852, 10'h220, 32'h79a8b120},
    '{2'h1, 32'h00000000, 32'h00ff8852, 10'h220, 32'hf3516240},
    '{2'h1, 32'h00000000, 32'h000088a6, 10'h200, 32'hf3516240},
    '{2'h1, 32'h00000000, 32'h00007742, 10'h220, 32'h00000000},
    '{2'h1, 32'h00000000, 32'h000088e6, 10'h220, 32'hf3516240},
    '{2'h2, 32'h00000000, 32'h0000bba3, 10'h001, 32'hffffffff},
    '{2'h2, 32'h00000000, 32'h000077a3, 10'h200, 32'hf3516240},
    '{2'h1, 32'h0000ffff, 32'h020088a0, 10'h000, 32'h0000ffff},
    '{2'h1, 32'h00000000, 32'h1e057743, 10'h220, 32'h00000000},
    '{2'h1, 32'h00ff00ff, 32'h02008840, 10'h020, 32'h00ff00ff},
    '{2'h1, 32'h0f0f0f0f, 32'h0e050000, 10'h040, 32'h0f0f0f0f},
    '{2'h1, 32'h00000000, 32'h16050002, 10'h040, 32'h0f0f0f0f},
    '{2'h1, 32'h00000000, 32'h060588a5, 10'h000, 32'h000ff0ff},
    '{2'h1, 32'h00000000, 32'h1a070003, 10'h000, 32'h000ff0ff},
    '{2'h1, 32'h00000000, 32'h02078845, 10'h020, 32'h000ff0ff},
    '{2'h1, 32'h00000000, 32'h000077a3, 10'h000, 32'h00000000},
    '{2'h1, 32'h00000000, 32'h16050001, 10'h040, 32'h0f0f0f0f},
    '{2'h1, 32'h00000000, 32'h060588a5, 10'h000, 32'h000ff0ff}
  };

  // --------------------------------------------------------------
  // Clock, design and bus master
  // --------------------------------------------------------------
  always #2.5 hclk = ~hclk;

  response_store_ops response_store_ops_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp)
  );
  ahb_master_model ahb_master_model_inst (
    .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  // --------------------------------------------------------------
  // Bus and compare tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] rd;
    ahb_master_model_inst.xfer(1'b1, {24'h0, ofs}, d, rd);
  endtask
  task automatic rd_check(input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] rd;
    ahb_master_model_inst.xfer(1'b0, {24'h0, ofs}, 32'h0, rd);
    check(rd, exp);
  endtask
  task automatic op(input logic [31:0] com, input logic [31:0] cmd);
    wr(`ARS_COMMON_OFS, com);
    wr(`ARS_CMD_OFS, cmd);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, then an unmapped read
    rd_check(`ARS_CMD_OFS, 32'h0);
    rd_check(`ARS_ENABLE_OFS, 32'h1);
    rd_check(`ARS_PTR_OFS, 32'h0);
    rd_check(`ARS_CNT_OFS, 32'h0);
    rd_check(8'h40, 32'h0);
    foreach (rows[i]) begin
      wr(`ARS_ENABLE_OFS, {30'h0, rows[i].en});
      op(rows[i].com, rows[i].cmd);
      wr(`ARS_VSEL_OFS, {22'h0, rows[i].vsel});
      rd_check(`ARS_VDATA_OFS, rows[i].exp);
    end
    // Plain copy from the operand, then resolve with every operand bit clear
    op(32'h000000a5, 32'h02008840);
    op(32'h0, 32'h000088a2);
    rd_check(`ARS_VDATA_OFS, 32'h000000a5);
    op(32'h0, 32'h00007742);
    op(32'h0, 32'h000088a6);
    rd_check(`ARS_VDATA_OFS, 32'h000000a5);
    // Stand-alone pointer and counter steps from known starting values
    wr(`ARS_PTR_OFS, 32'h00000010);
    wr(`ARS_CNT_OFS, 32'h00050505);
    op(32'h0, 32'h01340000);
    op(32'h0, 32'h01a00000);
    op(32'h0, 32'h01010000);
    op(32'h0, 32'h01030000);
    rd_check(`ARS_PTR_OFS, 32'h0001000f);
    rd_check(`ARS_CNT_OFS, 32'h00040504);
    rd_check(`ARS_CMD_OFS, 32'h01030000);
    // Common bit at pointer one picks OR or XOR; bit 0 would pick wrongly
    wr(`ARS_PTR_OFS, 32'h00000001);
    wr(`ARS_VSEL_OFS, 32'h0);
    op(32'h00000006, 32'h020088a0);
    op(32'h00000003, 32'h02009ca0);
    rd_check(`ARS_VDATA_OFS, 32'h00000007);
    op(32'h00000001, 32'h02009ca0);
    rd_check(`ARS_VDATA_OFS, 32'h00000006);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hready}, 32'h1);
    report_and_stop();
  end

  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // associative_response_store_ops_tb_top
`default_nettype wire
